// ---- pkg/atatf_regs.svh ----
`ifndef ATATF_REGS_SVH
`define ATATF_REGS_SVH

// register offsets
`define ATATF_OFF_DATA 4'h0
`define ATATF_OFF_ERR_FEAT 4'h1
`define ATATF_OFF_COUNT 4'h2
`define ATATF_OFF_SECTOR 4'h3
`define ATATF_OFF_CYL_LO 4'h4
`define ATATF_OFF_CYL_HI 4'h5
`define ATATF_OFF_DRV_HEAD 4'h6
`define ATATF_OFF_STATUS 4'h7
`define ATATF_OFF_DUP_EVEN 4'h8
`define ATATF_OFF_DUP_ODD 4'h9
`define ATATF_OFF_DUP_ERR 4'hd
`define ATATF_OFF_ALT_CTL 4'he
`define ATATF_OFF_DRV_ADDR 4'hf

// drive/head fields
`define ATATF_DH_FIXED 8'ha0
`define ATATF_DH_LBA 6
`define ATATF_DH_DRV 4

// device control fields
`define ATATF_DC_SOFT_RST 2
`define ATATF_DC_IEN_N 1

// error byte fields
`define ATATF_ERR_BBK 7
`define ATATF_ERR_UNC 6
`define ATATF_ERR_SECTOR_NOT_FOUND_FLAG 4
`define ATATF_ERR_COMMAND_ABORTED_FLAG 2
`define ATATF_ERR_GENERAL_ERROR_FLAG 0

// reset values
`define ATATF_RST_BYTE 8'h00
`define ATATF_RST_WORD 16'h0000

`endif

// ---- pkg/atatf_pkg.sv ----
package atatf_pkg;

    // target of one host access
    typedef enum logic [2:0] {
        ATATF_ACC_NONE,
        ATATF_ACC_DATA_WORD,
        ATATF_ACC_DATA_EVEN,
        ATATF_ACC_DATA_ODD_LO,
        ATATF_ACC_DATA_ODD_HI,
        ATATF_ACC_REG
    } atatf_acc_type;

endpackage : atatf_pkg

// ---- logic/atatf_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module atatf_pin_sync
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin side
    input wire logic [WIDTH-1:0] pin,
    // clocked side
    output logic [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } atatf_sync_state_type;

    atatf_sync_state_type state;
    atatf_sync_state_type next_state;

    always_comb
    begin
        next_state = state;
        next_state.s1 = pin;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // move only when stages two and three agree
        for (int i = 0; i < WIDTH; i++)
        begin
            if (state.s2[i] == state.s3[i])
            begin
                next_state.out[i] = state.s3[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.out;

endmodule : atatf_pin_sync

`default_nettype wire

// ---- logic/atatf_sector_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module atatf_sector_buffer
#(
    parameter int DEPTH = 256,
    parameter int AW = 8
)
(
    // clock
    input wire logic clk,
    // host port, byte enables per lane
    input wire logic [AW-1:0] host_addr,
    input wire logic [15:0] host_wdata,
    input wire logic [1:0] host_be,
    output logic [15:0] host_rdata,
    // engine port
    input wire logic [AW-1:0] eng_addr,
    input wire logic [15:0] eng_wdata,
    input wire logic eng_we,
    output logic [15:0] eng_rdata
);

    logic [15:0] mem [DEPTH];

    // array has no reset
    always_ff @(posedge clk)
    begin
        if (host_be[0])
        begin
            mem[host_addr][7:0] <= host_wdata[7:0];
        end
        if (host_be[1])
        begin
            mem[host_addr][15:8] <= host_wdata[15:8];
        end
        if (eng_we)
        begin
            mem[eng_addr] <= eng_wdata;
        end
        host_rdata <= mem[host_addr];
        eng_rdata <= mem[eng_addr];
    end

endmodule : atatf_sector_buffer

`default_nettype wire

// ---- logic/atatf_task_file.sv ----
// Functional notes
// - 16-bit data port moves buffer words or bytes
// - word access at offset one goes to the data port
// - offsets 8, 9, Dh accept any byte or word access
// - chip enables and A0 select data byte lanes
// - error/feature lanes: low lane for low-byte access at 1 or Dh, else high
// - error bits: bad block, uncorrectable, id missing, general
// - refused or invalid command sets aborted bit
// - error byte also on high lane at offset zero outside io_byte_mode
// - high-lane feature write at offset zero, not in true IDE or io_byte_mode
// - sector count zero means 256
// - engine reload: zero on success, remaining on failure
// - block address from sector, cylinders, head nibble
// - drive/head bits 7, 5 read one; bit 6 selects block mode
// - drive bit picks drive; PC Card mode uses copy field
// - head bits: head number or address bits 27-24
// - status mirrors alternate; primary read clears interrupt
// - busy locks host out of command register
// - ready low until engine ready; seek complete bit
// - data request and write fault status bits
// - corrected error status bit; bit 1 reads zero
// - error status bit set when error byte nonzero
// - soft reset bit holds controller in reset until cleared
// - interrupt disable bit masks interrupts, resets to zero
// - repeated data accesses step through buffer words
// - odd registers also answer one below on high lane unless io_byte_mode
`timescale 1ns/1ps
`default_nettype none

`include "atatf_regs.svh"

module atatf_task_file
    import atatf_pkg::*;
#(
    parameter int BUF_DEPTH = 256,
    parameter int BUF_AW = 8,
    parameter logic DRIVE_ID = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host socket pins
    input wire logic ce1_n,
    input wire logic ce2_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    // card configuration levels
    input wire logic true_ide_mode,
    input wire logic io_byte_mode,
    input wire logic copy_field,
    // command engine status
    input wire logic eng_busy,
    input wire logic eng_ready,
    input wire logic write_fault_bit,
    input wire logic seek_complete_bit,
    input wire logic transfer_request_bit,
    input wire logic corrected_error_bit,
    input wire logic intrq_event,
    // command engine error events, one-cycle pulses
    input wire logic bad_block_flag,
    input wire logic uncorrectable_flag,
    input wire logic sector_not_found_flag,
    input wire logic command_aborted_flag,
    input wire logic general_error_flag,
    // command engine count reload
    input wire logic count_load,
    input wire logic [7:0] count_value,
    // command engine outputs
    output logic command_strobe,
    output logic [7:0] command_code,
    output logic [7:0] feature_select,
    output logic [8:0] transfer_count,
    output logic lba_mode,
    output logic [27:0] block_address,
    output logic [15:0] cylinder,
    output logic [3:0] head,
    output logic [7:0] sector_number,
    output logic drive_select_bit,
    output logic card_selected,
    output logic soft_reset_bit,
    output logic interrupt_disable_n,
    output logic intrq,
    // engine port of the sector buffer
    input wire logic buf_ptr_clear,
    input wire logic [BUF_AW-1:0] eng_buf_addr,
    input wire logic [15:0] eng_buf_wdata,
    input wire logic eng_buf_we,
    output logic [15:0] eng_buf_rdata
);

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drv_head;
        logic [7:0] command;
        logic [7:0] err;
        logic soft_rst;
        logic ien_n;
        logic irq_pend;
        logic cmd_strobe;
        logic reading;
        logic writing;
        logic byte_odd;
        atatf_acc_type rd_kind;
        logic [BUF_AW-1:0] ptr;
        logic [15:0] dout;
    } atatf_tf_state_type;

    atatf_tf_state_type state;
    atatf_tf_state_type next_state;

    logic s_ce1_n;
    logic s_ce2_n;
    logic s_rd_n;
    logic s_wr_n;
    logic [3:0] s_addr;
    logic [15:0] s_din;
    logic [15:0] buf_rdata;
    logic [15:0] buf_wdata;
    logic [1:0] buf_be;
    logic selected;
    logic rd_now;
    logic wr_now;
    atatf_acc_type kind;
    logic [3:0] eff;
    logic hi_lane;
    logic [7:0] wbyte;
    logic [7:0] status;
    logic [7:0] rbyte;
    logic busy;
    logic cmd_ok;
    logic [7:0] err_set;

    // all socket pins share one four-stage delay
    atatf_pin_sync #(.WIDTH(24)) u_sync (
        .clk(clk),
        .rst(rst),
        .pin({ce1_n, ce2_n, rd_n, wr_n, addr, data_in}),
        .level({s_ce1_n, s_ce2_n, s_rd_n, s_wr_n, s_addr, s_din})
    );

    atatf_sector_buffer #(.DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (
        .clk(clk),
        .host_addr(state.ptr),
        .host_wdata(buf_wdata),
        .host_be(buf_be),
        .host_rdata(buf_rdata),
        .eng_addr(eng_buf_addr),
        .eng_wdata(eng_buf_wdata),
        .eng_we(eng_buf_we),
        .eng_rdata(eng_buf_rdata)
    );

    function automatic atatf_acc_type decode_access(input logic c1_n, input logic c2_n, input logic [3:0] off);
        logic word;
        logic lo;
        logic hi;
        logic dat01;
        logic dat89;
        word = !c1_n && !c2_n;
        lo = !c1_n && c2_n;
        hi = c1_n && !c2_n;
        dat01 = (off == `ATATF_OFF_DATA) || (off == `ATATF_OFF_ERR_FEAT);
        dat89 = (off == `ATATF_OFF_DUP_EVEN) || (off == `ATATF_OFF_DUP_ODD);
        if (word && (dat01 || dat89))
            return ATATF_ACC_DATA_WORD;
        else if (lo && (off == `ATATF_OFF_DATA || off == `ATATF_OFF_DUP_EVEN))
            return ATATF_ACC_DATA_EVEN;
        else if (lo && off == `ATATF_OFF_DUP_ODD)
            return ATATF_ACC_DATA_ODD_LO;
        else if (hi && dat89)
            return ATATF_ACC_DATA_ODD_HI;
        else if (word || lo || hi)
            return ATATF_ACC_REG;
        else
            return ATATF_ACC_NONE;
    endfunction : decode_access

    assign selected = !(s_ce1_n && s_ce2_n);
    assign rd_now = selected && !s_rd_n;
    assign wr_now = selected && !s_wr_n;
    assign kind = decode_access(s_ce1_n, s_ce2_n, s_addr);
    assign busy = eng_busy || state.soft_rst;

    always_comb
    begin
        // odd registers mirrored one below on the high lane unless io_byte_mode
        eff = s_addr;
        if (s_ce1_n && !s_ce2_n && !s_addr[0])
        begin
            eff = io_byte_mode ? `ATATF_OFF_DRV_ADDR : (s_addr | 4'h1);
        end
        hi_lane = (s_ce1_n && !s_ce2_n) || (!s_ce1_n && !s_ce2_n && s_addr == `ATATF_OFF_DUP_ERR);
        wbyte = hi_lane ? s_din[15:8] : s_din[7:0];
    end

    // status is composed live; reads take a registered copy
    assign status = {busy,
        eng_ready && !state.soft_rst,
        write_fault_bit,
        seek_complete_bit,
        transfer_request_bit,
        corrected_error_bit,
        1'b0,
        state.err != `ATATF_RST_BYTE};

    always_comb
    begin
        case (eff)
            `ATATF_OFF_ERR_FEAT, `ATATF_OFF_DUP_ERR: rbyte = state.err;
            `ATATF_OFF_COUNT: rbyte = state.count;
            `ATATF_OFF_SECTOR: rbyte = state.sector;
            `ATATF_OFF_CYL_LO: rbyte = state.cyl_lo;
            `ATATF_OFF_CYL_HI: rbyte = state.cyl_hi;
            `ATATF_OFF_DRV_HEAD: rbyte = state.drv_head | `ATATF_DH_FIXED;
            `ATATF_OFF_STATUS, `ATATF_OFF_ALT_CTL: rbyte = status;
            default: rbyte = `ATATF_RST_BYTE;
        endcase
    end

    always_comb
    begin
        cmd_ok = 1'b0;
        buf_be = 2'b00;
        buf_wdata = s_din;
        err_set = `ATATF_RST_BYTE;
        next_state = state;
        next_state.cmd_strobe = 1'b0;
        next_state.reading = rd_now;
        next_state.writing = wr_now;

        // read start: capture the answer for the whole strobe
        if (rd_now && !state.reading)
        begin
            next_state.rd_kind = kind;
            case (kind)
                ATATF_ACC_DATA_WORD: next_state.dout = buf_rdata;
                ATATF_ACC_DATA_EVEN:
                    next_state.dout = {8'h00, state.byte_odd ? buf_rdata[15:8] : buf_rdata[7:0]};
                ATATF_ACC_DATA_ODD_LO: next_state.dout = {8'h00, buf_rdata[15:8]};
                ATATF_ACC_DATA_ODD_HI: next_state.dout = {buf_rdata[15:8], 8'h00};
                ATATF_ACC_REG:
                begin
                    next_state.dout = hi_lane ? {rbyte, 8'h00} : {8'h00, rbyte};
                    if (eff == `ATATF_OFF_STATUS)
                    begin
                        next_state.irq_pend = 1'b0;
                    end
                end
                default: next_state.dout = `ATATF_RST_WORD;
            endcase
        end

        // read end: step pointer so next word prefetches
        if (!rd_now && state.reading)
        begin
            case (state.rd_kind)
                ATATF_ACC_DATA_EVEN:
                begin
                    next_state.byte_odd = !state.byte_odd;
                    if (state.byte_odd)
                    begin
                        next_state.ptr = state.ptr + 1'b1;
                    end
                end
                ATATF_ACC_DATA_WORD, ATATF_ACC_DATA_ODD_LO, ATATF_ACC_DATA_ODD_HI:
                begin
                    next_state.byte_odd = 1'b0;
                    next_state.ptr = state.ptr + 1'b1;
                end
                default: next_state.ptr = state.ptr;
            endcase
        end

        // write start
        if (wr_now && !state.writing)
        begin
            case (kind)
                ATATF_ACC_DATA_WORD:
                begin
                    buf_be = 2'b11;
                    next_state.byte_odd = 1'b0;
                    next_state.ptr = state.ptr + 1'b1;
                end
                ATATF_ACC_DATA_EVEN:
                begin
                    buf_wdata = {s_din[7:0], s_din[7:0]};
                    buf_be = state.byte_odd ? 2'b10 : 2'b01;
                    next_state.byte_odd = !state.byte_odd;
                    if (state.byte_odd)
                    begin
                        next_state.ptr = state.ptr + 1'b1;
                    end
                end
                ATATF_ACC_DATA_ODD_LO, ATATF_ACC_DATA_ODD_HI:
                begin
                    buf_wdata = {wbyte, wbyte};
                    buf_be = 2'b10;
                    next_state.byte_odd = 1'b0;
                    next_state.ptr = state.ptr + 1'b1;
                end
                ATATF_ACC_REG:
                begin
                    case (eff)
                        `ATATF_OFF_ERR_FEAT, `ATATF_OFF_DUP_ERR:
                        begin
                            if (!(true_ide_mode && s_addr == `ATATF_OFF_DATA))
                            begin
                                next_state.feature = wbyte;
                            end
                        end
                        `ATATF_OFF_COUNT: next_state.count = wbyte;
                        `ATATF_OFF_SECTOR: next_state.sector = wbyte;
                        `ATATF_OFF_CYL_LO: next_state.cyl_lo = wbyte;
                        `ATATF_OFF_CYL_HI: next_state.cyl_hi = wbyte;
                        `ATATF_OFF_DRV_HEAD: next_state.drv_head = wbyte | `ATATF_DH_FIXED;
                        `ATATF_OFF_STATUS:
                        begin
                            // ignored while busy
                            if (!busy)
                            begin
                                if (!status[6] || write_fault_bit)
                                begin
                                    err_set[`ATATF_ERR_COMMAND_ABORTED_FLAG] = 1'b1;
                                end
                                else
                                begin
                                    cmd_ok = 1'b1;
                                    next_state.command = wbyte;
                                    next_state.cmd_strobe = 1'b1;
                                end
                            end
                        end
                        `ATATF_OFF_ALT_CTL:
                        begin
                            next_state.soft_rst = wbyte[`ATATF_DC_SOFT_RST];
                            next_state.ien_n = wbyte[`ATATF_DC_IEN_N];
                        end
                        default: next_state.feature = state.feature;
                    endcase
                end
                default: next_state.ptr = state.ptr;
            endcase
        end

        if (count_load)
        begin
            next_state.count = count_value;
        end

        // set after clear: a same-cycle event survives
        err_set[`ATATF_ERR_BBK] = bad_block_flag;
        err_set[`ATATF_ERR_UNC] = uncorrectable_flag;
        err_set[`ATATF_ERR_SECTOR_NOT_FOUND_FLAG] = sector_not_found_flag;
        err_set[`ATATF_ERR_COMMAND_ABORTED_FLAG] = err_set[`ATATF_ERR_COMMAND_ABORTED_FLAG] || command_aborted_flag;
        err_set[`ATATF_ERR_GENERAL_ERROR_FLAG] = general_error_flag;
        next_state.err = ((cmd_ok || state.soft_rst) ? `ATATF_RST_BYTE : state.err) | err_set;

        if (state.soft_rst || buf_ptr_clear)
        begin
            next_state.ptr = '0;
            next_state.byte_odd = 1'b0;
        end
        if (state.soft_rst)
        begin
            next_state.irq_pend = 1'b0;
        end
        if (intrq_event)
        begin
            next_state.irq_pend = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
            state.rd_kind <= ATATF_ACC_NONE;
            state.drv_head <= `ATATF_DH_FIXED;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign data_out = state.dout;
    assign data_oe = state.reading;
    assign command_strobe = state.cmd_strobe;
    assign command_code = state.command;
    assign feature_select = state.feature;
    assign transfer_count = (state.count == `ATATF_RST_BYTE) ? 9'h100 : {1'b0, state.count};
    assign lba_mode = state.drv_head[`ATATF_DH_LBA];
    assign block_address = {state.drv_head[3:0], state.cyl_hi, state.cyl_lo, state.sector};
    assign cylinder = {state.cyl_hi, state.cyl_lo};
    assign head = state.drv_head[3:0];
    assign sector_number = state.sector;
    assign drive_select_bit = state.drv_head[`ATATF_DH_DRV];
    assign card_selected = drive_select_bit == (true_ide_mode ? DRIVE_ID : copy_field);
    assign soft_reset_bit = state.soft_rst;
    assign interrupt_disable_n = state.ien_n;
    assign intrq = state.irq_pend && !state.ien_n;

endmodule : atatf_task_file

`default_nettype wire

// ---- dv/atatf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module atatf_host_model
(
    // clock
    input wire logic clk,
    // socket pins
    output logic ce1_n,
    output logic ce2_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    output logic [15:0] data_in
);
    initial
    begin
        {ce2_n, ce1_n, rd_n, wr_n} = 4'hf;
        addr = 4'h0;
        data_in = 16'h0000;
    end

    // strobe held past the synchroniser; released bus shows inverse
    task automatic acc(input logic w, input logic [1:0] ce, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {ce2_n, ce1_n} <= ce;
        addr <= a;
        data_in <= w ? d : ~data_in;
        @(posedge clk);
        rd_n <= w;
        wr_n <= !w;
        repeat (8) @(posedge clk);
        {rd_n, wr_n} <= 2'b11;
        repeat (5) @(posedge clk);
        {ce2_n, ce1_n} <= 2'b11;
        data_in <= ~data_in;
    endtask : acc
endmodule : atatf_host_model

`default_nettype wire

// ---- dv/atatf_task_file_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module atatf_checker
#(
    parameter logic DRIVE_ID = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host side
    input wire logic rd_n,
    input wire logic data_oe,
    input wire logic true_ide_mode,
    input wire logic copy_field,
    // engine side
    input wire logic eng_busy,
    input wire logic intrq_event,
    input wire logic command_strobe,
    input wire logic [8:0] transfer_count,
    input wire logic lba_mode,
    input wire logic [27:0] block_address,
    input wire logic [15:0] cylinder,
    input wire logic [3:0] head,
    input wire logic [7:0] sector_number,
    input wire logic drive_select_bit,
    input wire logic card_selected,
    input wire logic soft_reset_bit,
    input wire logic interrupt_disable_n,
    input wire logic intrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_count_never_zero: assert property (transfer_count != 9'h000 && (!transfer_count[8] || transfer_count[7:0] == 8'h00))
        else $error("bad count");
    a_lba_assembly: assert property (lba_mode |-> block_address == {head, cylinder, sector_number})
        else $error("bad address");
    a_intrq_masked: assert property (interrupt_disable_n |-> !intrq)
        else $error("masked irq");
    a_intrq_raise: assert property (intrq_event && !interrupt_disable_n && !soft_reset_bit |=> intrq)
        else $error("no irq");
    a_command_lockout: assert property (command_strobe |-> $past(eng_busy) == 1'b0 && $past(soft_reset_bit) == 1'b0)
        else $error("busy command");
    a_read_answer: assert property ($rose(data_oe) |-> $past(rd_n, 3) == 1'b0)
        else $error("stray drive");
    a_read_release: assert property ($rose(rd_n) |-> ##[1:6] !data_oe)
        else $error("no release");
    a_card_select: assert property (card_selected == (drive_select_bit == (true_ide_mode ? DRIVE_ID : copy_field)))
        else $error("bad select");

    c_intrq: cover property ($rose(intrq));
    c_command: cover property (command_strobe);
    c_read: cover property ($rose(data_oe));
endmodule : atatf_checker

`default_nettype wire

// ---- dv/tb_ata_task_file_registers.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_ata_task_file_registers;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic true_ide_mode = 1'b0, copy_field = 1'b0, intrq_event = 1'b0, count_load = 1'b0;
    logic buf_ptr_clear = 1'b0, eng_buf_we = 1'b0, oe_q = 1'b0, io_byte_mode = 1'b0;
    logic [5:0] lv = 6'h00;
    logic [4:0] ef = 5'h00;
    logic [7:0] count_value = 8'h00, eng_buf_addr = 8'h00;
    logic [15:0] eng_buf_wdata = 16'h0000;
    logic ce1_n, ce2_n, rd_n, wr_n, data_oe, command_strobe, lba_mode, drive_select_bit;
    logic card_selected, soft_reset_bit, interrupt_disable_n, intrq;
    logic [3:0] addr, head;
    logic [7:0] command_code, feature_select, sector_number, v;
    logic [8:0] transfer_count;
    logic [15:0] data_in, data_out, cylinder, eng_buf_rdata;
    logic [27:0] block_address;
    logic [15:0] q[$];
    logic [15:0] w[6];
    int num_errors = 0;
    int tests_run = 0;
    int i;

    atatf_task_file i_atatf_task_file (
        .clk, .rst, .ce1_n, .ce2_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
        .true_ide_mode, .io_byte_mode, .copy_field, .eng_busy(lv[5]), .eng_ready(lv[4]),
        .write_fault_bit(lv[3]), .seek_complete_bit(lv[2]), .transfer_request_bit(lv[1]),
        .corrected_error_bit(lv[0]), .intrq_event, .bad_block_flag(ef[4]), .uncorrectable_flag(ef[3]),
        .sector_not_found_flag(ef[2]), .command_aborted_flag(ef[1]), .general_error_flag(ef[0]),
        .count_load, .count_value, .command_strobe, .command_code, .feature_select, .transfer_count,
        .lba_mode, .block_address, .cylinder, .head, .sector_number, .drive_select_bit, .card_selected,
        .soft_reset_bit, .interrupt_disable_n, .intrq, .buf_ptr_clear, .eng_buf_addr, .eng_buf_wdata,
        .eng_buf_we, .eng_buf_rdata
    );

    atatf_host_model i_atatf_host_model (.clk, .ce1_n, .ce2_n, .rd_n, .wr_n, .addr, .data_in);

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic rd(input logic [1:0] ce, input logic [3:0] a, input logic [15:0] e);
        q.push_back(e);
        i_atatf_host_model.acc(1'b0, ce, a, 16'h0000);
    endtask : rd

    task automatic wr(input logic [1:0] ce, input logic [3:0] a, input logic [15:0] d);
        i_atatf_host_model.acc(1'b1, ce, a, d);
    endtask : wr

    task automatic pulse_event;
        @(posedge clk);
        intrq_event <= 1'b1;
        @(posedge clk);
        intrq_event <= 1'b0;
        @(negedge clk);
    endtask : pulse_event

    task automatic summarize;
        if (q.size() != 0)
            num_errors++;
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // falling edge: read data settled
    always @(negedge clk)
    begin
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q === 1'b0)
        begin
            if (q.size() != 0)
                chk(data_out, q.pop_front());
            else
                num_errors++;
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end

    initial
    begin
        i = $urandom(67557);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            @(posedge clk);
            lv <= v[5:0];
            rd(2'b10, 4'h7, {8'h00, v[5:0], 2'b00});
            rd(2'b10, 4'he, {8'h00, v[5:0], 2'b00});
        end
        @(posedge clk);
        lv <= 6'b010100;
        for (i = 2; i < 7; i++)
        begin
            v = 8'($urandom);
            wr(2'b10, 4'(i), {8'h00, v});
            rd(2'b10, 4'(i), {8'h00, (i == 6) ? (v | 8'ha0) : v});
        end
        wr(2'b10, 4'h6, 16'h00fb);
        wr(2'b10, 4'h2, 16'h0000);
        chk(16'(transfer_count), 16'h0100);
        @(posedge clk);
        count_load <= 1'b1;
        count_value <= 8'h07;
        @(posedge clk);
        count_load <= 1'b0;
        rd(2'b10, 4'h2, 16'h0007);
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk);
            lv <= 6'b010100;
            v = 8'($urandom);
            wr(2'b10, 4'h7, {8'h00, v});
            chk(16'(command_code), {8'h00, v});
            rd(2'b10, 4'h1, 16'h0000);
            @(posedge clk);
            lv <= i ? 6'b011100 : 6'b000100;
            wr(2'b10, 4'h7, 16'h00ec);
            rd(2'b10, 4'h1, 16'h0004);
        end
        @(posedge clk);
        ef <= 5'h1f;
        @(posedge clk);
        ef <= 5'h00;
        rd(2'b10, 4'h1, 16'h00d5);
        rd(2'b01, 4'h0, 16'hd500);
        io_byte_mode <= 1'b1;
        rd(2'b01, 4'h0, 16'h0000);
        io_byte_mode <= 1'b0;
        rd(2'b00, 4'hd, 16'hd500);
        rd(2'b10, 4'h7, 16'h0071);
        wr(2'b01, 4'h0, 16'h3c00);
        chk(16'(feature_select), 16'h003c);
        @(posedge clk);
        true_ide_mode <= 1'b1;
        wr(2'b01, 4'h0, 16'h5a00);
        chk(16'(feature_select), 16'h003c);
        @(posedge clk);
        true_ide_mode <= 1'b0;
        copy_field <= 1'b1;
        wr(2'b00, 4'hd, 16'h77ff);
        chk(16'(feature_select), 16'h0077);
        for (i = 0; i < 6; i++)
        begin
            w[i] = 16'($urandom);
            @(posedge clk);
            eng_buf_addr <= 8'(i);
            eng_buf_wdata <= w[i];
            eng_buf_we <= 1'b1;
        end
        @(posedge clk);
        eng_buf_we <= 1'b0;
        buf_ptr_clear <= 1'b1;
        @(posedge clk);
        buf_ptr_clear <= 1'b0;
        rd(2'b00, 4'h0, w[0]);
        rd(2'b00, 4'h1, w[1]);
        rd(2'b00, 4'h8, w[2]);
        rd(2'b00, 4'h9, w[3]);
        rd(2'b10, 4'h0, {8'h00, w[4][7:0]});
        rd(2'b10, 4'h0, {8'h00, w[4][15:8]});
        rd(2'b01, 4'h9, {w[5][15:8], 8'h00});
        v = 8'($urandom);
        wr(2'b00, 4'h8, {v, ~v});
        eng_buf_addr <= 8'h06;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(eng_buf_rdata, {v, ~v});
        pulse_event();
        rd(2'b10, 4'he, 16'h0071);
        @(negedge clk);
        chk(16'(intrq), 16'h0001);
        rd(2'b10, 4'h7, 16'h0071);
        @(negedge clk);
        chk(16'(intrq), 16'h0000);
        wr(2'b10, 4'he, 16'h0002);
        pulse_event();
        chk(16'(intrq), 16'h0000);
        @(posedge clk);
        lv <= 6'b010100;
        wr(2'b10, 4'he, 16'h0004);
        @(negedge clk);
        chk(16'(soft_reset_bit), 16'h0001);
        rd(2'b10, 4'h7, 16'h0090);
        wr(2'b10, 4'he, 16'h0000);
        @(negedge clk);
        chk(16'({soft_reset_bit, interrupt_disable_n}), 16'h0000);
        summarize();
    end
endmodule : tb_ata_task_file_registers

bind atatf_task_file atatf_checker #(.DRIVE_ID(DRIVE_ID)) i_atatf_checker (
    .clk, .rst, .rd_n, .data_oe, .true_ide_mode, .copy_field, .eng_busy, .intrq_event, .command_strobe,
    .transfer_count, .lba_mode, .block_address, .cylinder, .head, .sector_number, .drive_select_bit,
    .card_selected, .soft_reset_bit, .interrupt_disable_n, .intrq
);

`default_nettype wire
